// ### verilog/phy_mode_cfg_pkg.sv
package phy_mode_cfg_pkg;

  // Byte offsets in configuration space
  localparam logic [7:0] OFS_LANE_DELTA = 8'h90;
  localparam logic [7:0] OFS_TX_MARGIN = 8'h94;
  localparam logic [7:0] OFS_OPMODE_CLK = 8'h98;

  // Lane mode and delta word
  localparam int LANE_MODE_LSB = 0;
  localparam int LANE_MODE_W = 7;
  localparam int DELTA_LSB = 15;
  localparam int DELTA_W = 17;
  localparam logic [16:0] DELTA_RST = 17'h00001;

  // Transmit margin word
  localparam int TX_MARGIN_LSB = 0;
  localparam int TX_MARGIN_W = 16;
  localparam logic [15:0] TX_MARGIN_RST = 16'h116B;

  // Operation mode word
  localparam int OPMODE_LSB = 0;
  localparam int OPMODE_W = 16;
  localparam logic [15:0] OPMODE_RST = 16'h0122;
  localparam int BOOT_ROM_BYPASS_BIT = 0;
  localparam int QUIESCENT_CURRENT_TEST_BIT = 1;
  localparam int FAST_MODE_BIT = 2;
  localparam int DEBUG_MODE_BIT = 3;
  localparam int PHY_MODE_BIT = 4;
  localparam int PACKAGE_SELECT_LSB = 5;
  localparam int LANE_CONFIGURATION_SELECT_LSB = 7;
  localparam int PAIR_EN_LSB = 16;
  localparam int PAIR_COUNT = 7;
  localparam logic [6:0] PAIR_EN_RST = 7'h1F;
  localparam int CLK_GLOBAL_DIS_BIT = 23;
  localparam int L1PM_LSB = 24;
  localparam int L1PM_W = 4;
  localparam logic [3:0] L1PM_RST = 4'h0;

  // Control byte six, retrain suppression
  localparam int RETRAIN_DIS_BIT = 0;

  // Cycles after reset release until the synchronised strap is valid
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

endpackage

// ### verilog/phy_mode_cfg_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Global disable bit twenty-three at one stops all clock outputs
// - Seven per-pair enables, one enables that pair
// - Per-pair enable field resets to 1Fh
// - Global disable resets to sampled powerdown strap
// - Control bit zero suppresses physical-error retrain
// - Loaders may overwrite read-only defaults after reset
// - Global fields live only in upstream port
// - Lane mode is low seven bits
// - Delta is bits 31:15, resets 0_0001h
// - Tx margin low sixteen bits, resets 116Bh
// - Operation mode low sixteen bits, resets 0122h
module phy_mode_cfg_regs
  import phy_mode_cfg_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b1,
  parameter logic [7:0] CTRL6_RST = 8'h00
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Configuration space access
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // SMBus, I2C or EEPROM autoload
  input wire logic load_wr_i,
  input wire logic [7:0] load_addr_i,
  input wire logic [31:0] load_data_i,
  input wire logic load_ctrl6_i,
  input wire logic [7:0] load_ctrl6_data_i,
  // Strap pin
  input wire logic clock_buffer_powerdown_strap_i,
  // Controls to the physical layer and clock buffers
  output logic [LANE_MODE_W-1:0] lane_mode_o,
  output logic [DELTA_W-1:0] delta_o,
  output logic [TX_MARGIN_W-1:0] tx_margin_o,
  output logic [OPMODE_W-1:0] operation_mode_o,
  output logic [L1PM_W-1:0] l1pm_option_o,
  output logic retrain_disable_o,
  output logic [PAIR_COUNT:1] reference_clock_output_pairs_en_o
);

  import phy_mode_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic strap_s1;
    logic strap_s2;
    logic [1:0] settle;
    logic strap_done;
    logic [31:0] lane_delta;
    logic [31:0] tx_margin;
    logic [31:0] opmode_clk;
    logic [7:0] ctrl6;
    logic [31:0] rdata;
    logic rvalid;
    logic [PAIR_COUNT:1] pair_en;
  } state_t;

  localparam logic [31:0] LANE_DELTA_RST =
    {(IS_UPSTREAM ? DELTA_RST : 17'h00000), 15'h0000};
  localparam logic [31:0] TX_MARGIN_WORD_RST =
    {16'h0000, (IS_UPSTREAM ? TX_MARGIN_RST : 16'h0000)};
  // Global disable starts at zero; the strap is taken once settled
  localparam logic [31:0] OPMODE_WORD_RST =
    {4'h0, L1PM_RST, 1'b0,
     (IS_UPSTREAM ? PAIR_EN_RST : 7'h00), OPMODE_RST};

  state_t q;
  state_t d;

  // Global fields are masked so a downstream port never holds them
  localparam logic [31:0] LANE_DELTA_MASK =
    IS_UPSTREAM ? 32'hFFFFFFFF : 32'h00007FFF;
  localparam logic [31:0] TX_MARGIN_MASK =
    IS_UPSTREAM ? 32'hFFFFFFFF : 32'h00000000;
  localparam logic [31:0] OPMODE_MASK =
    IS_UPSTREAM ? 32'hFFFFFFFF : 32'hFF00FFFF;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.strap_s1 = clock_buffer_powerdown_strap_i;
    d.strap_s2 = q.strap_s1;
    d.rvalid = cfg_rd_i;
    if (q.settle != STRAP_SETTLE) begin
      d.settle = q.settle + 2'h1;
    end
    // Strap lands once; a loader write in the same cycle wins
    if (!q.strap_done && q.settle == STRAP_SETTLE) begin
      d.strap_done = 1'b1;
      if (IS_UPSTREAM) begin
        d.opmode_clk[CLK_GLOBAL_DIS_BIT] = q.strap_s2;
      end
    end
    // Loader path; cfg_wr_i and cfg_wdata_i are ignored on purpose
    if (load_wr_i) begin
      if (load_addr_i == OFS_LANE_DELTA) begin
        d.lane_delta = load_data_i & LANE_DELTA_MASK;
      end else if (load_addr_i == OFS_TX_MARGIN) begin
        d.tx_margin = load_data_i & TX_MARGIN_MASK;
      end else if (load_addr_i == OFS_OPMODE_CLK) begin
        d.opmode_clk = load_data_i & OPMODE_MASK;
      end
    end
    if (load_ctrl6_i) begin
      d.ctrl6 = load_ctrl6_data_i;
    end
    // Reads return stored words, reserved bits included
    d.rdata = 32'h00000000;
    if (cfg_rd_i) begin
      if (cfg_addr_i == OFS_LANE_DELTA) begin
        d.rdata = q.lane_delta;
      end else if (cfg_addr_i == OFS_TX_MARGIN) begin
        d.rdata = q.tx_margin;
      end else if (cfg_addr_i == OFS_OPMODE_CLK) begin
        d.rdata = q.opmode_clk;
      end
    end
    // Pair enables use the current word so outputs track it in one cycle
    for (int i = 1; i <= PAIR_COUNT; i++) begin
      d.pair_en[i] = IS_UPSTREAM &&
        !q.opmode_clk[CLK_GLOBAL_DIS_BIT] &&
        q.opmode_clk[PAIR_EN_LSB + i - 1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q.strap_s1 <= 1'b0;
      q.strap_s2 <= 1'b0;
      q.settle <= 2'h0;
      q.strap_done <= 1'b0;
      q.lane_delta <= LANE_DELTA_RST;
      q.tx_margin <= TX_MARGIN_WORD_RST;
      q.opmode_clk <= OPMODE_WORD_RST;
      q.ctrl6 <= CTRL6_RST;
      q.rdata <= 32'h00000000;
      q.rvalid <= 1'b0;
      q.pair_en <= 7'h00;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign cfg_rdata_o = q.rdata;
  assign cfg_rvalid_o = q.rvalid;
  assign lane_mode_o = q.lane_delta[LANE_MODE_LSB +: LANE_MODE_W];
  assign delta_o = q.lane_delta[DELTA_LSB +: DELTA_W];
  assign tx_margin_o = q.tx_margin[TX_MARGIN_LSB +: TX_MARGIN_W];
  assign operation_mode_o = q.opmode_clk[OPMODE_LSB +: OPMODE_W];
  assign l1pm_option_o = q.opmode_clk[L1PM_LSB +: L1PM_W];
  assign retrain_disable_o = q.ctrl6[RETRAIN_DIS_BIT];
  assign reference_clock_output_pairs_en_o = q.pair_en;

endmodule

// ### tb/cfg_regs_props.sv
`timescale 1ns/1ps
module cfg_regs_props (
  // Clock, reset, config write, loader and strap
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic cfg_wr_i,
  input wire logic load_wr_i,
  input wire logic [7:0] load_addr_i,
  input wire logic [31:0] load_data_i,
  input wire logic clock_buffer_powerdown_strap_i,
  // Register outputs
  input wire logic [16:0] delta_o,
  input wire logic [15:0] tx_margin_o,
  input wire logic [15:0] operation_mode_o,
  input wire logic [7:1] reference_clock_output_pairs_en_o
);
  wire [7:1] pe = reference_clock_output_pairs_en_o;
  wire [6:0] ld_en = load_data_i[22:16];
  wire ld98 = load_wr_i && load_addr_i == 8'h98;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_pair_reset: assert property ($rose(rst_b_i) |-> ##1 pe == 7'h1F)
    else $error("pairs not 1F after reset");
  chk_strap_disable: assert property ($rose(rst_b_i) |-> ##4
    pe == (clock_buffer_powerdown_strap_i ? 7'h00 : 7'h1F))
    else $error("strap not applied");
  chk_global_off: assert property (ld98 && load_data_i[23] |->
    ##2 pe == 7'h00)
    else $error("global disable ignored");
  chk_pair_enable: assert property (ld98 && !load_data_i[23] |->
    ##2 pe == $past(ld_en, 2))
    else $error("pair enables wrong");
  chk_delta_reset: assert property ($rose(rst_b_i) |->
    delta_o == 17'h00001)
    else $error("delta reset wrong");
  chk_margin_reset: assert property ($rose(rst_b_i) |->
    tx_margin_o == 16'h116B)
    else $error("margin reset wrong");
  chk_mode_reset: assert property ($rose(rst_b_i) |->
    operation_mode_o == 16'h0122)
    else $error("mode reset wrong");
  // Loads stay a few cycles clear of writes, so any change is the write's
  chk_write_ignored: assert property (cfg_wr_i && !load_wr_i |=>
    $stable(operation_mode_o) && $stable(tx_margin_o))
    else $error("config write changed a field");
endmodule
////////////////////////////////////////////////////////////////////////
bind phy_mode_cfg_regs cfg_regs_props i_props (.sys_clk_i, .rst_b_i,
  .cfg_wr_i, .load_wr_i, .load_addr_i, .load_data_i,
  .clock_buffer_powerdown_strap_i, .delta_o, .tx_margin_o,
  .operation_mode_o, .reference_clock_output_pairs_en_o);

// ### tb/phy_mode_cfg_regs_bench.sv
`timescale 1ns/1ps
module phy_mode_cfg_regs_bench;
  logic sys_clk_i = 1'b0, rst_b_i = 1'b0, cfg_rd_i = 1'b0, cfg_wr_i = 1'b0;
  logic load_wr_i = 1'b0, load_ctrl6_i = 1'b0;
  logic clock_buffer_powerdown_strap_i = 1'b1, cfg_rvalid_o;
  logic [7:0] cfg_addr_i = 8'h00, load_addr_i = 8'h00, a;
  logic [7:0] load_ctrl6_data_i = 8'h00;
  logic [31:0] cfg_wdata_i = 32'h0, load_data_i = 32'h0, d, cfg_rdata_o;
  logic [31:0] w [3];
  logic retrain_disable_o;
  logic [6:0] lane_mode_o;
  logic [16:0] delta_o;
  logic [15:0] tx_margin_o, operation_mode_o;
  logic [3:0] l1pm_option_o;
  logic [7:1] reference_clock_output_pairs_en_o;
  int seed = 32'h39F3, n_mismatch = 0, check_count = 0, k;
  phy_mode_cfg_regs i_dut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cfg_rd_i(cfg_rd_i),
    .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .cfg_rvalid_o(cfg_rvalid_o), .load_wr_i(load_wr_i),
    .load_addr_i(load_addr_i), .load_data_i(load_data_i),
    .load_ctrl6_i(load_ctrl6_i), .load_ctrl6_data_i(load_ctrl6_data_i),
    .clock_buffer_powerdown_strap_i(clock_buffer_powerdown_strap_i),
    .lane_mode_o(lane_mode_o), .delta_o(delta_o),
    .tx_margin_o(tx_margin_o), .operation_mode_o(operation_mode_o),
    .l1pm_option_o(l1pm_option_o), .retrain_disable_o(retrain_disable_o),
    .reference_clock_output_pairs_en_o(reference_clock_output_pairs_en_o)
  );
  always #2.5 sys_clk_i = ~sys_clk_i;
  function automatic logic [6:0] pairs_exp(input logic [31:0] x);
    return x[23] ? 7'h00 : x[22:16];
  endfunction
  task automatic ck(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic outs();
    ck("lane", 32'(w[0][6:0]), 32'(lane_mode_o));
    ck("delta", 32'(w[0][31:15]), 32'(delta_o));
    ck("margin", 32'(w[1][15:0]), 32'(tx_margin_o));
    ck("mode", 32'(w[2][15:0]), 32'(operation_mode_o));
    ck("pairs", 32'(pairs_exp(w[2])), 32'(reference_clock_output_pairs_en_o));
    ck("retrain", 32'(load_ctrl6_data_i[0]), 32'(retrain_disable_o));
    ck("l1pm", 32'(w[2][27:24]), 32'(l1pm_option_o));
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    @(posedge sys_clk_i);
    cfg_rd_i <= 1'b1;
    cfg_addr_i <= ad;
    @(posedge sys_clk_i);
    cfg_rd_i <= 1'b0;
    #1;
    ck("rvalid", 32'h1, 32'(cfg_rvalid_o));
    ck("rdata", e, cfg_rdata_o);
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    // Second pass resets in mid-run, after loads, with the strap low
    for (int s = 1; s >= 0; s--) begin
      @(posedge sys_clk_i);
      rst_b_i <= 1'b0;
      clock_buffer_powerdown_strap_i <= s[0];
      // Control byte six returns to its zero default in reset
      load_ctrl6_data_i <= 8'h00;
      repeat (16) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      w[0] = 32'h0000_8000;
      w[1] = 32'h0000_116B;
      w[2] = {8'h00, s[0], 23'h1F_0122};
      repeat (6) @(posedge sys_clk_i);
      #1;
      outs();
      for (k = 0; k < 3; k++) rd(8'h90 + 8'(4 * k), w[k]);
      rd(8'h9C, 32'h0);
      for (int i = 0; i < 12; i++) begin
        k = i < 2 ? 2 : $unsigned($random(seed)) % 3;
        d = i == 0 ? 32'h0080_0000 : i == 1 ? 32'h007F_0000 : $random(seed);
        a = 8'h90 + 8'(4 * k);
        @(posedge sys_clk_i);
        load_wr_i <= 1'b1;
        load_addr_i <= a;
        load_data_i <= d;
        load_ctrl6_i <= 1'b1;
        load_ctrl6_data_i <= d[7:0];
        @(posedge sys_clk_i);
        load_wr_i <= 1'b0;
        load_ctrl6_i <= 1'b0;
        w[k] = d;
        repeat (3) @(posedge sys_clk_i);
        cfg_wr_i <= 1'b1;
        cfg_addr_i <= a;
        cfg_wdata_i <= ~d;
        @(posedge sys_clk_i);
        cfg_wr_i <= 1'b0;
        rd(a, d);
        outs();
      end
    end
    summarize();
  end
endmodule
